// ---- rtl/bscp_top.sv ----
// What this block does
// - the protection level comes from a pattern in a flash word, and no valid pattern means open access.
// - programming commands from the running application are allowed at every level.
// - a stored setting can turn off the strap request for the handler with no protection level active.
// - level one locks debug and allows a limited command set that may update every sector except sector 0.
// - level two locks debug and allows only reading the ID, a full erase, and reprogramming after that erase.
// - level three locks debug, starts no handler at reset and ignores the request strap; an application reinvoke still starts the serial handler.
// - once level three is active, factory test access is refused with no way back.
// - the reset-time request strap sampling can be switched off on its own; the code check still applies.
// - after every reset the boot decision runs and starts either the application or the handler.
// - the request strap held low at reset asks for the handler.
// - the port select strap at reset picks serial when high and CAN when low.
// - the CAN handler offers the same command functions as the serial one.
//
// Purpose: boot target selection and code protection gate
// Assumes: flash controller returns the protection word on request; straps synchronous to i_clk
// Notes: commands are checked, not executed; software reads the verdict
`timescale 1ns/1ps
`include "bscp_consts.svh"

module bscp_top
    import bscp_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // straps
    input wire logic i_handler_request_strap,
    input wire logic i_port_select_strap,
    // flash protection word
    input wire logic [31:0] i_pattern_word,
    input wire logic i_pattern_valid,
    input wire logic i_user_code_valid,
    output logic o_pattern_rd,
    // register port
    input wire logic [`BSCP_ADDR_W-1:0] i_addr,
    input wire logic [`BSCP_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [`BSCP_DATA_W-1:0] o_rdata,
    // boot and access outputs
    output logic o_boot_done,
    output logic o_boot_handler,
    output logic o_port_can,
    output logic o_debug_en,
    output logic o_test_en,
    output logic [1:0] o_level
);

    // ****************************************
    // state
    // ****************************************
    bscp_state_t state_q;
    bscp_state_t state_d;
    bscp_level_t level_q;
    logic no_req_q;
    logic no_sample_q;
    logic code_ok_q;
    logic req_low_q;
    logic port_high_q;
    logic erased_q;
    logic res_valid_q;
    logic res_ok_q;
    logic pattern_rd_q;
    logic [`BSCP_DATA_W-1:0] rdata_q;
    logic boot_done_q;
    logic boot_handler_q;
    logic port_can_q;
    logic debug_en_q;
    logic test_en_q;

    bscp_level_t dec_level;
    logic dec_no_req;
    logic dec_no_sample;

    bscp_pattern_decode u_decode (
        .i_word(i_pattern_word),
        .i_word_valid(i_pattern_valid),
        .o_level(dec_level),
        .o_no_req(dec_no_req),
        .o_no_sample(dec_no_sample)
    );

    // ****************************************
    // sequence decode
    // ****************************************
    wire logic in_reset_st;
    wire logic in_fetch;
    wire logic in_decide;
    wire logic in_run;
    wire logic fetch_done;

    assign in_reset_st = (state_q == BSCP_ST_RESET);
    assign in_fetch = (state_q == BSCP_ST_FETCH);
    assign in_decide = (state_q == BSCP_ST_DECIDE);
    assign in_run = (state_q == BSCP_ST_RUN);
    assign fetch_done = in_fetch && i_pattern_valid;

    always_comb begin
        case (state_q)
            BSCP_ST_RESET: state_d = BSCP_ST_FETCH;
            BSCP_ST_FETCH: state_d = i_pattern_valid ? BSCP_ST_DECIDE : BSCP_ST_FETCH;
            BSCP_ST_DECIDE: state_d = BSCP_ST_RUN;
            BSCP_ST_RUN: state_d = BSCP_ST_RUN;
            default: state_d = BSCP_ST_RESET;
        endcase
    end

    // every reset walks the whole decision again
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= BSCP_ST_RESET;
        end else if (i_clk_en) begin
            state_q <= state_d;
        end
    end

    // straps caught at the first enabled edge after release, never again
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req_low_q <= 1'b0;
            port_high_q <= 1'b1;
        end else if (i_clk_en && in_reset_st) begin
            req_low_q <= !i_handler_request_strap;
            port_high_q <= i_port_select_strap;
        end
    end

    // level and disables held until next reset
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            level_q <= BSCP_LVL_OPEN;
            no_req_q <= 1'b0;
            no_sample_q <= 1'b0;
            code_ok_q <= 1'b0;
        end else if (i_clk_en && fetch_done) begin
            level_q <= dec_level;
            no_req_q <= dec_no_req;
            no_sample_q <= dec_no_sample;
            code_ok_q <= i_user_code_valid;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pattern_rd_q <= 1'b0;
        end else if (i_clk_en) begin
            pattern_rd_q <= (state_d == BSCP_ST_FETCH);
        end
    end

    // ****************************************
    // boot decision
    // ****************************************
    wire logic lvl_three;
    wire logic strap_heard;
    wire logic want_handler;
    wire logic reinvoke_wr;

    assign lvl_three = (level_q == BSCP_LVL_THREE);
    // level three and both stored disables mask the strap
    assign strap_heard = !lvl_three && !no_req_q && !no_sample_q;
    // low strap is an external request; missing user code also falls back to the handler, except at level three
    assign want_handler = (strap_heard && req_low_q) || (!lvl_three && !code_ok_q);
    // the application may reinvoke the serial handler even at level three
    assign reinvoke_wr = in_run && i_wr && (i_addr == `BSCP_OFS_CTRL) && i_wdata[`BSCP_CTRL_REINVOKE_BIT];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            boot_done_q <= 1'b0;
            boot_handler_q <= 1'b0;
            port_can_q <= 1'b0;
        end else if (i_clk_en && in_decide) begin
            boot_done_q <= 1'b1;
            boot_handler_q <= want_handler;
            port_can_q <= !port_high_q;
        end else if (i_clk_en && reinvoke_wr) begin
            boot_handler_q <= 1'b1;
            port_can_q <= 1'b0;
        end
    end

    // debug open only without a level; test access dies at level three
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            debug_en_q <= 1'b0;
            test_en_q <= 1'b0;
        end else if (i_clk_en && in_decide) begin
            debug_en_q <= (level_q == BSCP_LVL_OPEN);
            test_en_q <= !lvl_three;
        end
    end

    // ****************************************
    // command gate
    // ****************************************
    wire logic cmd_wr;
    wire bscp_op_t cmd_op;
    wire logic [3:0] cmd_sect;
    wire logic cmd_from_app;
    wire logic sect_nonzero;
    wire logic lvl1_ok;
    wire logic lvl2_ok;
    wire logic handler_ok;
    wire logic cmd_ok;

    assign cmd_wr = in_run && i_wr && (i_addr == `BSCP_OFS_CMD);
    assign cmd_op = bscp_op_t'(i_wdata[`BSCP_CMD_OP_MSB:`BSCP_CMD_OP_LSB]);
    assign cmd_sect = i_wdata[`BSCP_CMD_SECT_MSB:`BSCP_CMD_SECT_LSB];
    assign cmd_from_app = i_wdata[`BSCP_CMD_SRC_BIT];
    assign sect_nonzero = (cmd_sect != `BSCP_SECT_ZERO);

    // limited set, sector 0 kept out of every write and erase
    assign lvl1_ok = (cmd_op == BSCP_OP_WRITE_RAM) || (cmd_op == BSCP_OP_PREPARE && sect_nonzero) ||
                     (cmd_op == BSCP_OP_COPY_FLASH && sect_nonzero) || (cmd_op == BSCP_OP_READ_ID) ||
                     (cmd_op == BSCP_OP_ERASE_SECT && sect_nonzero) ||
                     (cmd_op == BSCP_OP_BLANK_CHECK && sect_nonzero);
    // full erase first, programming only after it
    assign lvl2_ok = (cmd_op == BSCP_OP_ERASE_ALL) || (cmd_op == BSCP_OP_READ_ID) ||
                     (erased_q && ((cmd_op == BSCP_OP_WRITE_RAM) || (cmd_op == BSCP_OP_PREPARE) ||
                     (cmd_op == BSCP_OP_COPY_FLASH)));

    // the same gate serves the serial and the CAN handler
    assign handler_ok = (level_q == BSCP_LVL_OPEN) ? 1'b1 :
                        (level_q == BSCP_LVL_ONE) ? lvl1_ok :
                        (level_q == BSCP_LVL_TWO) ? lvl2_ok : 1'b0;
    // application calls never see the protection level
    assign cmd_ok = cmd_from_app || handler_ok;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            res_valid_q <= 1'b0;
            res_ok_q <= 1'b0;
        end else if (i_clk_en && cmd_wr) begin
            res_valid_q <= 1'b1;
            res_ok_q <= cmd_ok;
        end
    end

    // erase-then-program memory for level two
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            erased_q <= 1'b0;
        end else if (i_clk_en && cmd_wr && !cmd_from_app && cmd_op == BSCP_OP_ERASE_ALL && handler_ok) begin
            erased_q <= 1'b1;
        end
    end

    // ****************************************
    // read port
    // ****************************************
    wire logic [`BSCP_DATA_W-1:0] status_word;
    wire logic [`BSCP_DATA_W-1:0] result_word;
    wire logic [`BSCP_DATA_W-1:0] rd_mux;

    assign status_word = {18'h0, erased_q, no_sample_q, no_req_q, code_ok_q,
                          port_high_q, req_low_q, test_en_q, debug_en_q,
                          port_can_q, boot_handler_q, boot_done_q, 1'b0, level_q};
    assign result_word = {30'h0, res_valid_q, res_ok_q};
    // unmapped and write-only offsets read zero
    assign rd_mux = (i_addr == `BSCP_OFS_STATUS) ? status_word :
                    (i_addr == `BSCP_OFS_RESULT) ? result_word : `BSCP_RDATA_RST;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_q <= `BSCP_RDATA_RST;
        end else if (i_clk_en) begin
            rdata_q <= i_rd ? rd_mux : `BSCP_RDATA_RST;
        end
    end

    assign o_pattern_rd = pattern_rd_q;
    assign o_rdata = rdata_q;
    assign o_boot_done = boot_done_q;
    assign o_boot_handler = boot_handler_q;
    assign o_port_can = port_can_q;
    assign o_debug_en = debug_en_q;
    assign o_test_en = test_en_q;
    assign o_level = level_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_fetch_taken;
        in_fetch && i_pattern_valid && i_clk_en;
    endsequence

    sequence s_decided;
        i_clk_en ##1 o_boot_done;
    endsequence

    chk_boot_sequence: assert property (s_fetch_taken |=> s_decided)
        else $error("boot decision not made after pattern fetch");

    chk_open_default: assert property ((s_fetch_taken and (dec_level == BSCP_LVL_OPEN))
        |=> level_q == BSCP_LVL_OPEN)
        else $error("unknown pattern did not leave access open");

    chk_debug_lock: assert property (o_boot_done && level_q != BSCP_LVL_OPEN |-> !o_debug_en)
        else $error("debug port open under protection");

    chk_test_lock: assert property (o_boot_done && level_q == BSCP_LVL_THREE |-> !o_test_en)
        else $error("test access open at level three");

    chk_level3_strap: assert property ($rose(o_boot_done) && level_q == BSCP_LVL_THREE
        |-> !o_boot_handler)
        else $error("level three started the handler");

    chk_strap_request: assert property ($rose(o_boot_done) && strap_heard && req_low_q
        |-> o_boot_handler)
        else $error("low request strap ignored");

    chk_strap_off: assert property ($rose(o_boot_done) && (no_req_q || no_sample_q) && code_ok_q
        |-> !o_boot_handler)
        else $error("disabled strap still started the handler");

    chk_port_select: assert property ($rose(o_boot_done) |-> o_port_can == !port_high_q)
        else $error("port choice differs from strap");

    chk_app_free: assert property (cmd_wr && cmd_from_app && i_clk_en |=> res_ok_q)
        else $error("application command refused");

    chk_sector_zero: assert property (cmd_wr && !cmd_from_app && level_q == BSCP_LVL_ONE
        && !sect_nonzero && cmd_op == BSCP_OP_ERASE_SECT && i_clk_en |=> !res_ok_q)
        else $error("sector 0 erase accepted at level one");

    chk_level2_set: assert property (cmd_wr && !cmd_from_app && level_q == BSCP_LVL_TWO
        && cmd_op == BSCP_OP_READ_MEM && i_clk_en |=> !res_ok_q)
        else $error("memory read accepted at level two");

    chk_latch_hold: assert property (o_boot_done |=> $stable(level_q) && $stable(req_low_q))
        else $error("latched boot inputs changed");

endmodule

// ---- rtl/bscp_consts.svh ----
// Purpose: offsets, field positions and pattern values for the boot select and code protect block
// Assumes: byte addresses on an 8-bit register port, 32-bit data
// Notes: definitions only
`ifndef BSCP_CONSTS_SVH
`define BSCP_CONSTS_SVH

// ****************************************
// register port
// ****************************************
`define BSCP_ADDR_W 8
`define BSCP_DATA_W 32
`define BSCP_OFS_STATUS 8'h00
`define BSCP_OFS_CMD 8'h04
`define BSCP_OFS_RESULT 8'h08
`define BSCP_OFS_CTRL 8'h0c

// ****************************************
// command word fields
// ****************************************
`define BSCP_CMD_OP_LSB 0
`define BSCP_CMD_OP_MSB 3
`define BSCP_CMD_SECT_LSB 4
`define BSCP_CMD_SECT_MSB 7
`define BSCP_CMD_SRC_BIT 8
`define BSCP_CTRL_REINVOKE_BIT 0

// ****************************************
// protection patterns (values are arbitrary)
// ****************************************
`define BSCP_PAT_LVL_ONE 32'h5a5a_0001
`define BSCP_PAT_LVL_TWO 32'h5a5a_0002
`define BSCP_PAT_LVL_THREE 32'h5a5a_0003
`define BSCP_PAT_NO_REQ 32'h5a5a_0010
`define BSCP_PAT_NO_SAMPLE 32'h5a5a_0020

// ****************************************
// reset values
// ****************************************
`define BSCP_RDATA_RST 32'h0000_0000
`define BSCP_SECT_ZERO 4'h0

`endif

// ---- rtl/bscp_pkg.sv ----
// Purpose: types of the boot select and code protect block
// Assumes: nothing
// Notes: state codes are gray along reset, fetch, decide, run
package bscp_pkg;

    typedef enum logic [2:0] {
        BSCP_ST_RESET  = 3'b000,
        BSCP_ST_FETCH  = 3'b001,
        BSCP_ST_DECIDE = 3'b011,
        BSCP_ST_RUN    = 3'b010
    } bscp_state_t;

    typedef enum logic [1:0] {
        BSCP_LVL_OPEN  = 2'h0,
        BSCP_LVL_ONE   = 2'h1,
        BSCP_LVL_TWO   = 2'h2,
        BSCP_LVL_THREE = 2'h3
    } bscp_level_t;

    typedef enum logic [3:0] {
        BSCP_OP_READ_MEM    = 4'h0,
        BSCP_OP_WRITE_RAM   = 4'h1,
        BSCP_OP_PREPARE     = 4'h2,
        BSCP_OP_COPY_FLASH  = 4'h3,
        BSCP_OP_ERASE_SECT  = 4'h4,
        BSCP_OP_ERASE_ALL   = 4'h5,
        BSCP_OP_GO          = 4'h6,
        BSCP_OP_BLANK_CHECK = 4'h7,
        BSCP_OP_READ_ID     = 4'h8,
        BSCP_OP_REINVOKE    = 4'h9
    } bscp_op_t;

endpackage

// ---- rtl/bscp_pattern_decode.sv ----
// Purpose: turns the stored protection word into a level and two strap disables
// Assumes: word is qualified by its valid input
// Notes: anything unknown means no protection
`timescale 1ns/1ps
`include "bscp_consts.svh"

module bscp_pattern_decode
    import bscp_pkg::*;
(
    // stored word
    input wire logic [31:0] i_word,
    input wire logic i_word_valid,
    // decoded
    output bscp_level_t o_level,
    output logic o_no_req,
    output logic o_no_sample
);

    // ****************************************
    // pattern match
    // ****************************************
    wire logic hit_one;
    wire logic hit_two;
    wire logic hit_three;

    assign hit_one = i_word_valid && (i_word == `BSCP_PAT_LVL_ONE);
    assign hit_two = i_word_valid && (i_word == `BSCP_PAT_LVL_TWO);
    assign hit_three = i_word_valid && (i_word == `BSCP_PAT_LVL_THREE);

    // no valid pattern leaves access open
    assign o_level = hit_three ? BSCP_LVL_THREE :
                     hit_two ? BSCP_LVL_TWO :
                     hit_one ? BSCP_LVL_ONE : BSCP_LVL_OPEN;

    // strap request can be turned off with no protection level
    assign o_no_req = i_word_valid && (i_word == `BSCP_PAT_NO_REQ);
    // request strap sampling can be turned off on its own
    assign o_no_sample = i_word_valid && (i_word == `BSCP_PAT_NO_SAMPLE);

endmodule

// ---- verification/bscp_flash_model.sv ----
// Purpose: flash side that answers the protection word fetch
// Assumes: fetch request stays high until the word is taken
// Notes: answers after a settable number of cycles, 0 is prompt
`timescale 1ns/1ps

module bscp_flash_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // fetch handshake
    input wire logic i_fetch,
    input wire logic [31:0] i_stored,
    input wire logic [3:0] i_delay,
    output logic [31:0] o_word,
    output logic o_valid
);
    // ****************************************
    // fetch answer
    // ****************************************
    logic [3:0] wait_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wait_q <= 4'h0;
            o_valid <= 1'b0;
            o_word <= 32'h0000_0000;
        end else if (i_fetch && !o_valid && wait_q >= i_delay) begin
            o_valid <= 1'b1;
            o_word <= i_stored;
        end else if (i_fetch && !o_valid) begin
            wait_q <= wait_q + 4'h1;
        end else if (!i_fetch) begin
            wait_q <= 4'h0;
            o_valid <= 1'b0;
            // released bus keeps toggling so a stale word never looks valid
            o_word <= ~o_word;
        end
    end
endmodule

// ---- verification/bscp_top_tb.sv ----
// Purpose: self-checking bench for boot selection and protection gating
// Assumes: clock enable held high except around one reinvoke write per boot; one boot per reset
// Notes: read results go through a queue checked by a monitor
`timescale 1ns/1ps
`include "bscp_consts.svh"

module bscp_top_tb;
    // ****************************************
    // signals
    // ****************************************
    logic clk, reset_n, req, port, ucv, wr, rd, fetch, pvalid, rd_d, en;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, pword, stored, em, mm;
    logic [3:0] dly;
    logic done, hnd, can, dbg, tst;
    logic [1:0] lvl;
    int error_cnt, total_checks, cyc;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] seed = 32'h0000_7442;
    logic [31:0] pats [7] = '{`BSCP_PAT_LVL_ONE, `BSCP_PAT_LVL_TWO, `BSCP_PAT_LVL_THREE,
        `BSCP_PAT_NO_REQ, `BSCP_PAT_NO_SAMPLE, 32'h1234_5678, 32'h5a5a_0004};

    bscp_top bscp_top_inst (.i_clk(clk), .i_reset_n(reset_n), .i_clk_en(en),
        .i_handler_request_strap(req), .i_port_select_strap(port), .i_pattern_word(pword),
        .i_pattern_valid(pvalid), .i_user_code_valid(ucv), .o_pattern_rd(fetch), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_boot_done(done),
        .o_boot_handler(hnd), .o_port_can(can), .o_debug_en(dbg), .o_test_en(tst), .o_level(lvl));

    bscp_flash_model bscp_flash_model_inst (.i_clk(clk), .i_reset_n(reset_n), .i_fetch(fetch),
        .i_stored(stored), .i_delay(dly), .o_word(pword), .o_valid(pvalid));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // handler commands are gated by level, application ones never
    function automatic bit alw(int l, int op, int s, bit app, bit er);
        if (app || l == 0) return 1'b1;
        if (l == 1) return op == 1 || op == 8 || (s != 0 && (op == 2 || op == 3 || op == 4 || op == 7));
        if (l == 2) return op == 5 || op == 8 || (er && op >= 1 && op <= 3);
        return 1'b0;
    endfunction

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // read monitor and timeout
    // ****************************************
    always @(posedge clk) begin
        rd_d <= rd;
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            give_verdict();
        end
    end

    always @(negedge clk) begin
        if (rd_d && exp_q.size() == 0) begin
            check("queue", 32'h1, 32'h0);
        end else if (rd_d) begin
            em = exp_q.pop_front();
            mm = msk_q.pop_front();
            check("rdata", rdata & mm, em & mm);
        end
    end

    // ****************************************
    // one boot with commands
    // ****************************************
    task boot_run(input int k);
        int l, op, s;
        bit u, h, er, app;
        logic [31:0] r, st, m;
        r = nxt();
        u = r[0];
        l = (k % 7 < 3) ? k % 7 + 1 : 0;
        @(posedge clk);
        reset_n <= 1'b0;
        stored <= pats[k % 7];
        req <= k[0];
        port <= k[1];
        ucv <= u;
        dly <= r[11:8];
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge clk);
        @(negedge clk);
        h = (!k[0] && l != 3 && k % 7 != 3 && k % 7 != 4) || (!u && l != 3);
        check("done", done, 1);
        check("level", lvl, l);
        check("handler", hnd, h);
        check("port", can, !k[1]);
        check("debug", dbg, l == 0);
        check("test", tst, l != 3);
        st = {19'h0, k % 7 == 4, k % 7 == 3, u, k[1], !k[0], l != 3, l == 0, !k[1], h, 1'b1, 1'b0, l[1:0]};
        m = 32'hffff_ffff;
        // straps move after boot and a write to the read-only word must not land
        @(posedge clk);
        req <= !k[0];
        port <= !k[1];
        wr_reg(`BSCP_OFS_STATUS, 32'hffff_ffff);
        rd_reg(`BSCP_OFS_STATUS, st, m);
        rd_reg(8'h10, 32'h0, 32'hffff_ffff);
        // a reinvoke written while the enable is low must not land
        en <= 1'b0;
        wr_reg(`BSCP_OFS_CTRL, 32'h1);
        @(negedge clk);
        check("frozen", {hnd, can}, {h, !k[1]});
        @(posedge clk);
        en <= 1'b1;
        er = 1'b0;
        repeat (12) begin
            r = nxt();
            op = r[3:0] % 10;
            s = r[7:4];
            app = r[8];
            wr_reg(`BSCP_OFS_CMD, {23'h0, app, s[3:0], op[3:0]});
            rd_reg(`BSCP_OFS_RESULT, {30'h0, 1'b1, alw(l, op, s, app, er)}, 32'hffff_ffff);
            if (l == 2 && !app && op == 5) er = 1'b1;
        end
        // handler erase of sector 0 every boot
        wr_reg(`BSCP_OFS_CMD, 32'h0000_0004);
        rd_reg(`BSCP_OFS_RESULT, {30'h0, 1'b1, alw(l, 4, 0, 1'b0, er)}, 32'hffff_ffff);
        wr_reg(`BSCP_OFS_CTRL, 32'h1);
        @(negedge clk);
        check("reinvoke", {hnd, can}, 2'b10);
        check("test_kept", tst, l != 3);
        $display("test %0d done", k);
    endtask

    initial begin
        reset_n = 1'b0;
        req = 1'b1;
        port = 1'b1;
        ucv = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        rd_d = 1'b0;
        en = 1'b1;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        stored = 32'h0000_0000;
        dly = 4'h0;
        for (int k = 0; k < 28; k++) boot_run(k);
        repeat (3) @(posedge clk);
        give_verdict();
    end
endmodule
